//--- gcd_pkg.sv
// Constants, field layouts and carrier types for the gauge configuration decoder
`default_nettype none
package gcd_pkg;
    // Configuration memory byte addresses
    localparam logic [6:0] EE_CHECK1_LO  = 7'h00;
    localparam logic [6:0] EE_CHECK1_HI  = 7'h01;
    localparam logic [6:0] EE_TIME_LO    = 7'h02;
    localparam logic [6:0] EE_TIME_HI    = 7'h03;
    localparam logic [6:0] EE_CAP_LO     = 7'h04;
    localparam logic [6:0] EE_CAP_HI     = 7'h05;
    localparam logic [6:0] EE_SAFE_TEMP  = 7'h08;
    localparam logic [6:0] EE_SAFE_OV    = 7'h1f;
    localparam logic [6:0] EE_TEMP_LIMIT = 7'h45;
    localparam logic [6:0] EE_CELL_UVOV  = 7'h4a;
    localparam logic [6:0] EE_CTL_MODE   = 7'h51;
    localparam logic [6:0] EE_CC_OFF0    = 7'h5e;
    localparam logic [6:0] EE_CC_OFF1    = 7'h5f;
    localparam logic [6:0] EE_CC_OFF2    = 7'h60;
    localparam logic [6:0] EE_TEMP_OFF   = 7'h61;
    localparam logic [6:0] EE_ADC_OFF    = 7'h62;
    localparam logic [6:0] EE_PACK_PROG  = 7'h63;
    localparam logic [6:0] EE_VGAIN_LO   = 7'h66;
    localparam logic [6:0] EE_VGAIN_HI   = 7'h67;
    localparam logic [6:0] EE_IGAIN_LO   = 7'h68;
    localparam logic [6:0] EE_IGAIN_HI   = 7'h69;
    localparam logic [6:0] EE_CHECK2_LO  = 7'h7e;
    localparam logic [6:0] EE_LAST       = 7'h7f;
    localparam logic [15:0] CHECK1_VALUE = 16'h3c7f;
    localparam logic [15:0] CHECK2_VALUE = 16'ha55a;
    // Field positions
    localparam int CM_FILTER  = 7;
    localparam int CM_HOST_PEC = 5;
    localparam int CM_CHG_PEC = 4;
    localparam int CM_LED4    = 3;
    localparam int CM_SMART   = 2;
    localparam int CM_INHIBIT = 0;
    localparam int PP_LEARN_SEL = 4;
    localparam int CC_SIGN    = 20;
    // Decode constants (mV and tenths of a degree)
    localparam logic [15:0] OV_BASE_MV  = 16'h1000;
    localparam logic [15:0] UV_BASE_MV  = 16'h0800;
    localparam int          OV_STEP_SH  = 5;
    localparam int          UV_STEP_SH  = 6;
    localparam int          SAFE_OV_STEP_SH = 6;
    localparam logic [15:0] OVERTEMP_BASE_DT = 16'h03b1;
    localparam logic [15:0] LOWT_FIXED_DT = 16'h0078;
    localparam logic [15:0] LOWT_STEP_DT = 16'h0008;
    localparam int VGAIN_SH = 16;
    localparam int IGAIN_SH = 14;
    localparam logic [2:0] LED_FIVE = 3'h5;
    localparam logic [2:0] LED_FOUR = 3'h4;
    // Protector settle time before each conversion
    localparam int SETTLE_NS    = 10000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_CYC   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Avalon register byte addresses
    localparam logic [7:0] RA_STATUS  = 8'h00;
    localparam logic [7:0] RA_CONTROL = 8'h04;
    localparam logic [7:0] RA_CELL0   = 8'h08;
    localparam logic [7:0] RA_CURRENT = 8'h18;
    localparam logic [7:0] RA_TEMP    = 8'h1c;
    localparam logic [7:0] RA_LIMITS  = 8'h20;
    localparam logic [7:0] RA_SAFETY  = 8'h24;
    localparam logic [7:0] RA_ALARMS  = 8'h28;
    localparam logic [7:0] RA_MODES   = 8'h2c;
    localparam logic [7:0] RA_CCOFF   = 8'h30;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    // Raw configuration image
    typedef struct packed {
        logic [15:0] time_alarm;
        logic [15:0] cap_alarm;
        logic [7:0]  safe_temp;
        logic [7:0]  safe_ov;
        logic [7:0]  temp_limit;
        logic [7:0]  cell_uvov;
        logic [7:0]  ctl_mode;
        logic [23:0] cc_off;
        logic [7:0]  temp_off;
        logic [7:0]  adc_off;
        logic [7:0]  pack_prog;
        logic [15:0] vgain;
        logic [15:0] igain;
        logic [15:0] check1;
        logic [15:0] check2;
    } gcd_cfg_s;
    // Tri-state pin as drive value and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } gcd_pin_s;
endpackage : gcd_pkg
`default_nettype wire

//--- gcd_top.sv
// Gauge configuration loader, decoder, cell scan sequencer and calibration
`default_nettype none
// Behaviour
// - Learn fault threshold: fixed 12C or nibble
// - Time and capacity alarms from bytes 2-5
// - Byte 0x4a gives over/under cell limits
// - Safety overvoltage 4096 plus 64 per step
// - Safety overtemp code equals (94.5-T)*10
// - Control-mode byte 0x51 field layout
// - Filter off in discharge with bus idle
// - Host alarm PEC follows host checksum bit
// - Charger PEC follows charger checksum bit
// - LED count bit selects five or four
// - Charger-type bit selects learning optimisation
// - Inhibit blocks broadcasts, mode bits cannot override
// - Select pins high/open/low pick offset or scaled
// - Cell voltage equals difference times gain/65536
// - Voltage gain from bytes 0x66-0x67
// - Most positive cell reported as cell four
// - Current equals (adc+offset)*gain/16384
// - Byte 0x62 signed current offset
// - Charge-counter offset 20-bit magnitude plus sign
// - Temperature offset in tenths from byte 0x61
// - Low-temp nibble steps of 0.8 degrees
module gcd_top (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    // Avalon-MM slave
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    // Configuration memory byte port
    output logic                     mem_rd_req,
    output logic [6:0]               mem_addr,
    input  wire logic                mem_ack,
    input  wire logic [7:0]          mem_data,
    // Protector select pins and ADC
    output gcd_pkg::gcd_pin_s        cell_select_hi,
    output gcd_pkg::gcd_pin_s        cell_select_lo,
    output logic                     adc_start,
    input  wire logic                adc_done,
    input  wire logic signed [15:0]  cell_sense_input,
    input  wire logic signed [15:0]  current_adc,
    input  wire logic signed [15:0]  temp_raw_dt,
    // System conditions
    input  wire logic                discharging,
    input  wire logic                smbc_high,
    input  wire logic                smbd_high,
    input  wire logic                mode_broadcast_en,
    // Decoded controls
    output logic                     filter_enable,
    output logic                     host_pec_enable,
    output logic                     charger_pec_enable,
    output logic                     broadcast_enable,
    output logic                     smart_charger_learning,
    output logic [2:0]               led_segments,
    output logic                     cfg_ready,
    output logic                     check_error
);
    typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_DONE} gcd_load_e;
    typedef enum logic [1:0] {SCAN_IDLE, SCAN_SETTLE, SCAN_CONV} gcd_scan_e;

    gcd_load_e          load_state;
    gcd_scan_e          scan_state;
    gcd_pkg::gcd_cfg_s  cfg;
    logic               ack_q;
    logic [31:0]        control;
    logic [2:0]         step;
    logic [15:0]        settle_cnt;
    logic signed [15:0] offset_rd;
    logic signed [15:0] cell_mv [4];
    logic signed [15:0] current_ma;
    logic signed [15:0] temp_cal_dt;

    // Decoded configuration fields
    wire [7:0]  ctl_mode                = cfg.ctl_mode;
    wire        filter_off_when_idle    = ctl_mode[gcd_pkg::CM_FILTER];
    wire        host_checksum_enable    = ctl_mode[gcd_pkg::CM_HOST_PEC];
    wire        charger_checksum_enable = ctl_mode[gcd_pkg::CM_CHG_PEC];
    wire        led_four                = ctl_mode[gcd_pkg::CM_LED4];
    wire        broadcast_inhibit       = ctl_mode[gcd_pkg::CM_INHIBIT];
    wire        learn_lowtemp_select    = cfg.pack_prog[gcd_pkg::PP_LEARN_SEL];
    wire [3:0]  lowtemp_code            = cfg.temp_limit[3:0];
    wire [15:0] cell_over_limit  = gcd_pkg::OV_BASE_MV
                                   + (16'(cfg.cell_uvov[3:0]) << gcd_pkg::OV_STEP_SH);
    wire [15:0] cell_under_limit = gcd_pkg::UV_BASE_MV
                                   + (16'(cfg.cell_uvov[7:4]) << gcd_pkg::UV_STEP_SH);
    wire [15:0] safety_over_limit = gcd_pkg::OV_BASE_MV
                                    + (16'(cfg.safe_ov) << gcd_pkg::SAFE_OV_STEP_SH);
    wire [15:0] safety_overtemp_limit = gcd_pkg::OVERTEMP_BASE_DT - 16'(cfg.safe_temp);
    wire [15:0] low_temp_fault_level = learn_lowtemp_select
                                       ? 16'(lowtemp_code * gcd_pkg::LOWT_STEP_DT)
                                       : gcd_pkg::LOWT_FIXED_DT;
    wire        cc_sign = cfg.cc_off[gcd_pkg::CC_SIGN];
    wire [19:0] cc_mag  = cfg.cc_off[19:0];
    wire signed [21:0] charge_counter_offset_value = cc_sign ? -$signed({2'b00, cc_mag})
                                                             : $signed({2'b00, cc_mag});
    wire signed [7:0]  temp_offset_value = $signed(cfg.temp_off);

    // Control outputs: PEC, broadcast and learning held off until configuration has loaded, filter held on
    assign filter_enable = !(cfg_ready && filter_off_when_idle && discharging
                             && smbc_high && smbd_high);
    assign host_pec_enable        = cfg_ready && host_checksum_enable;
    assign charger_pec_enable     = cfg_ready && charger_checksum_enable;
    assign broadcast_enable       = cfg_ready && !broadcast_inhibit
                                    && mode_broadcast_en;
    assign smart_charger_learning = cfg_ready && ctl_mode[gcd_pkg::CM_SMART];
    assign led_segments = led_four ? gcd_pkg::LED_FOUR : gcd_pkg::LED_FIVE;
    assign cfg_ready    = (load_state == LD_DONE);

    // Avalon decode
    wire        bus_req   = avs_read || avs_write;
    wire        ctl_hit   = avs_address == gcd_pkg::RA_CONTROL;
    wire        wr_ctl    = avs_write && ack_q && ctl_hit && avs_byteenable[0];
    wire        reload    = wr_ctl && avs_writedata[0];
    wire        scan_on   = control[1];
    assign avs_waitrequest = bus_req && !ack_q;

    // One wait state per access
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req && !ack_q;
        end
    end

    // Control register: bit 0 reload strobe, bit 1 cell scan enable
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            control <= gcd_pkg::CONTROL_RESET;
        end else if (wr_ctl) begin
            control <= {30'h0000_0000, avs_writedata[1], 1'b0};
        end
    end

    // Read mux
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        case (avs_address)
            gcd_pkg::RA_STATUS:  rd_word = {29'h0, load_state == LD_REQ, check_error, cfg_ready};
            gcd_pkg::RA_CONTROL: rd_word = control;
            gcd_pkg::RA_CURRENT: rd_word = {{16{current_ma[15]}}, current_ma};
            gcd_pkg::RA_TEMP:    rd_word = {{16{temp_cal_dt[15]}}, temp_cal_dt};
            gcd_pkg::RA_LIMITS:  rd_word = {cell_under_limit, cell_over_limit};
            gcd_pkg::RA_SAFETY:  rd_word = {safety_overtemp_limit, safety_over_limit};
            gcd_pkg::RA_ALARMS:  rd_word = {cfg.cap_alarm, cfg.time_alarm};
            gcd_pkg::RA_MODES:   rd_word = {low_temp_fault_level, 8'h00, ctl_mode};
            gcd_pkg::RA_CCOFF:   rd_word = {{10{charge_counter_offset_value[21]}},
                                            charge_counter_offset_value};
            default: begin
                if (avs_address >= gcd_pkg::RA_CELL0 && avs_address < gcd_pkg::RA_CURRENT) begin
                    rd_word = {{16{cell_mv[avs_address[3:2] - 2'd2][15]}},
                               cell_mv[avs_address[3:2] - 2'd2]};
                end
            end
        endcase
    end

    // Read data registered at the wait-state edge, stable for the answering edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rd_word;
        end
    end

    // Configuration loader walks the whole memory after reset and again on each reload
    assign mem_rd_req = (load_state == LD_REQ);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            load_state <= LD_IDLE;
            mem_addr   <= 7'h00;
        end else begin
            case (load_state)
                LD_IDLE: begin
                    load_state <= LD_REQ;
                    mem_addr   <= 7'h00;
                end
                LD_REQ: begin
                    if (mem_ack) begin
                        if (mem_addr == gcd_pkg::EE_LAST) begin
                            load_state <= LD_DONE;
                        end
                        mem_addr <= mem_addr + 7'h01;
                    end
                end
                LD_DONE: begin
                    if (reload) begin
                        load_state <= LD_IDLE;
                    end
                end
                default: load_state <= LD_IDLE;
            endcase
        end
    end

    // Latch each byte of interest as it arrives
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= '0;
        end else if (mem_rd_req && mem_ack) begin
            case (mem_addr)
                gcd_pkg::EE_CHECK1_LO:  cfg.check1[7:0]   <= mem_data;
                gcd_pkg::EE_CHECK1_HI:  cfg.check1[15:8]  <= mem_data;
                gcd_pkg::EE_TIME_LO:    cfg.time_alarm[7:0]  <= mem_data;
                gcd_pkg::EE_TIME_HI:    cfg.time_alarm[15:8] <= mem_data;
                gcd_pkg::EE_CAP_LO:     cfg.cap_alarm[7:0]   <= mem_data;
                gcd_pkg::EE_CAP_HI:     cfg.cap_alarm[15:8]  <= mem_data;
                gcd_pkg::EE_SAFE_TEMP:  cfg.safe_temp  <= mem_data;
                gcd_pkg::EE_SAFE_OV:    cfg.safe_ov    <= mem_data;
                gcd_pkg::EE_TEMP_LIMIT: cfg.temp_limit <= mem_data;
                gcd_pkg::EE_CELL_UVOV:  cfg.cell_uvov  <= mem_data;
                gcd_pkg::EE_CTL_MODE:   cfg.ctl_mode   <= mem_data;
                gcd_pkg::EE_CC_OFF0:    cfg.cc_off[7:0]   <= mem_data;
                gcd_pkg::EE_CC_OFF1:    cfg.cc_off[15:8]  <= mem_data;
                gcd_pkg::EE_CC_OFF2:    cfg.cc_off[23:16] <= mem_data;
                gcd_pkg::EE_TEMP_OFF:   cfg.temp_off   <= mem_data;
                gcd_pkg::EE_ADC_OFF:    cfg.adc_off    <= mem_data;
                gcd_pkg::EE_PACK_PROG:  cfg.pack_prog  <= mem_data;
                gcd_pkg::EE_VGAIN_LO:   cfg.vgain[7:0]  <= mem_data;
                gcd_pkg::EE_VGAIN_HI:   cfg.vgain[15:8] <= mem_data;
                gcd_pkg::EE_IGAIN_LO:   cfg.igain[7:0]  <= mem_data;
                gcd_pkg::EE_IGAIN_HI:   cfg.igain[15:8] <= mem_data;
                gcd_pkg::EE_CHECK2_LO:  cfg.check2[7:0]  <= mem_data;
                gcd_pkg::EE_LAST:       cfg.check2[15:8] <= mem_data;
                default: ;
            endcase
        end
    end

    // Check words compared once the image is complete
    assign check_error = cfg_ready && (cfg.check1 != gcd_pkg::CHECK1_VALUE
                                       || cfg.check2 != gcd_pkg::CHECK2_VALUE);

    // Select pin pairs per scan step: even steps offset, odd steps scaled cell
    logic [1:0] hi_lvl;
    logic [1:0] lo_lvl;
    always_comb begin
        case (step)
            3'd0:    begin hi_lvl = 2'b11; lo_lvl = 2'b11; end
            3'd1:    begin hi_lvl = 2'b11; lo_lvl = 2'b00; end
            3'd2:    begin hi_lvl = 2'b11; lo_lvl = 2'b01; end
            3'd3:    begin hi_lvl = 2'b00; lo_lvl = 2'b11; end
            3'd4:    begin hi_lvl = 2'b00; lo_lvl = 2'b00; end
            3'd5:    begin hi_lvl = 2'b00; lo_lvl = 2'b01; end
            3'd6:    begin hi_lvl = 2'b01; lo_lvl = 2'b11; end
            default: begin hi_lvl = 2'b01; lo_lvl = 2'b00; end
        endcase
    end
    // Level code: 11 high, 01 low, 00 open (not driven)
    assign cell_select_hi = '{out: hi_lvl[1], oe: hi_lvl[0]};
    assign cell_select_lo = '{out: lo_lvl[1], oe: lo_lvl[0]};

    // Cell voltage arithmetic
    wire signed [16:0] cell_diff = 17'(cell_sense_input) - 17'(offset_rd);
    wire signed [33:0] cell_prod = 34'(cell_diff) * $signed({18'h0_0000, cfg.vgain});
    wire signed [15:0] next_cell = cell_prod[gcd_pkg::VGAIN_SH +: 16];
    wire [1:0]         cell_slot = 2'd3 - step[2:1];
    assign adc_start = (scan_state == SCAN_SETTLE) && (settle_cnt == 16'h0000) && cfg_ready;

    // Scan sequencer: settle, convert, store, advance; a reload parks it in idle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scan_state <= SCAN_IDLE;
            step       <= 3'd0;
            settle_cnt <= 16'h0000;
            offset_rd  <= 16'sh0000;
            for (int i = 0; i < 4; i++) begin
                cell_mv[i] <= 16'sh0000;
            end
        end else begin
            case (scan_state)
                SCAN_IDLE: begin
                    if (cfg_ready && scan_on) begin
                        scan_state <= SCAN_SETTLE;
                        settle_cnt <= 16'(gcd_pkg::SETTLE_CYC - 1);
                    end
                end
                SCAN_SETTLE: begin
                    if (!cfg_ready) begin
                        scan_state <= SCAN_IDLE;
                    end else if (settle_cnt == 16'h0000) begin
                        scan_state <= SCAN_CONV;
                    end else begin
                        settle_cnt <= settle_cnt - 16'h0001;
                    end
                end
                SCAN_CONV: begin
                    if (adc_done) begin
                        if (!step[0]) begin
                            offset_rd <= cell_sense_input;
                        end else begin
                            cell_mv[cell_slot] <= next_cell;
                        end
                        step       <= step + 3'd1;
                        scan_state <= (cfg_ready && scan_on) ? SCAN_SETTLE : SCAN_IDLE;
                        settle_cnt <= 16'(gcd_pkg::SETTLE_CYC - 1);
                    end
                end
                default: scan_state <= SCAN_IDLE;
            endcase
        end
    end

    // Current and temperature calibration, refreshed every cycle after load
    wire signed [16:0] cur_sum  = 17'(current_adc) + 17'($signed(cfg.adc_off));
    wire signed [33:0] cur_prod = 34'(cur_sum) * $signed({18'h0_0000, cfg.igain});
    wire signed [15:0] next_current = cur_prod[gcd_pkg::IGAIN_SH +: 16];
    wire signed [15:0] next_temp = temp_raw_dt + 16'(temp_offset_value);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            current_ma  <= 16'sh0000;
            temp_cal_dt <= 16'sh0000;
        end else if (cfg_ready) begin
            current_ma  <= next_current;
            temp_cal_dt <= next_temp;
        end
    end

    // Checks
    bus_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");
    scan_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !cfg_ready |-> !adc_start)
        else $error("conversion before configuration loaded");
    load_end_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(cfg_ready) |-> $past(mem_addr) == gcd_pkg::EE_LAST)
        else $error("load finished early");
    select_open_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        step == 3'd4 |-> !cell_select_hi.oe && !cell_select_lo.oe)
        else $error("select pins driven on open pair");
    cell_store_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        scan_state == SCAN_CONV && adc_done && step == 3'd1
        |=> cell_mv[3] == $past(next_cell))
        else $error("top cell not stored");
    inhibit_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        broadcast_inhibit |-> !broadcast_enable)
        else $error("broadcast with inhibit set");
    led_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        led_segments == (ctl_mode[gcd_pkg::CM_LED4] ? 3'd4 : 3'd5))
        else $error("led count wrong");
    current_upd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_ready ##1 cfg_ready |-> current_ma == $past(next_current))
        else $error("current not refreshed");
    settle_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(scan_state == SCAN_SETTLE) |-> !adc_start [*8])
        else $error("conversion before settle");
endmodule : gcd_top
`default_nettype wire

//--- gcd_partner.sv
// Model of the configuration memory and of the cell protector with its ADC
`default_nettype none
module gcd_partner (
    // Clock
    input  wire logic              ref_clk,
    // Memory byte port
    input  wire logic              mem_rd_req,
    input  wire logic [6:0]        mem_addr,
    output logic                   mem_ack,
    output logic [7:0]             mem_data,
    // Protector pins and ADC
    input  wire gcd_pkg::gcd_pin_s cell_select_hi,
    input  wire gcd_pkg::gcd_pin_s cell_select_lo,
    input  wire logic              adc_start,
    output logic                   adc_done,
    output logic signed [15:0]     cell_sense_input
);
    timeunit 1ns;
    timeprecision 100ps;
    // Image as {address, byte}; bytes not listed read zero
    localparam logic [15:0] IMG [23] = '{16'h007f, 16'h013c, 16'h0234, 16'h0312, 16'h0478,
        16'h0556, 16'h0832, 16'h1f05, 16'h4505, 16'h4af3, 16'h51bd, 16'h5ee8, 16'h5f03,
        16'h6010, 16'h6105, 16'h62fe, 16'h6310, 16'h6600, 16'h6740, 16'h6800, 16'h6940,
        16'h7e5a, 16'h7fa5};
    int step;
    int wait_cnt = 0;
    int conv_cnt = 0;
    logic [15:0] vout;
    function automatic logic [7:0] rom(input logic [6:0] a);
        rom = 8'h00;
        foreach (IMG[i]) if (IMG[i][14:8] == a) rom = IMG[i][7:0];
    endfunction : rom
    function automatic int lvl(input gcd_pkg::gcd_pin_s p);
        lvl = p.oe ? (p.out ? 0 : 2) : 1;
    endfunction : lvl
    initial begin
        mem_ack = 1'b0;
        adc_done = 1'b0;
    end
    // Slow memory: a byte every other cycle, garbage outside the ack cycle
    always @(posedge ref_clk) mem_ack <= mem_rd_req & !mem_ack;
    assign mem_data = mem_ack ? rom(mem_addr) : ~rom(mem_addr);
    // Pin pair picks offset (even step) or offset plus scaled cell (odd step)
    assign step = lvl(cell_select_hi) * 3 + lvl(cell_select_lo);
    assign vout = step[0] ? 16'h0100 + 16'(step) * 16'h0100 : 16'h0100;
    assign cell_sense_input = adc_done ? vout : ~vout;
    // Conversion finishes three cycles after start
    always @(posedge ref_clk) begin
        adc_done <= (wait_cnt == 1);
        if (adc_start) wait_cnt <= 3;
        else if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
        if (wait_cnt == 1) conv_cnt <= conv_cnt + 1;
    end
endmodule : gcd_partner
`default_nettype wire

//--- gcd_tb.sv
// Self-checking bench for the gauge configuration decoder
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
    logic avs_waitrequest, mem_rd_req, mem_ack, adc_start, adc_done, filt, hpec, cpec;
    logic bc_en, smart, rdy, chk_err, dis = 1'b0, smbc = 1'b0, smbd = 1'b0;
    logic [6:0] mem_addr;
    logic [7:0] mem_data;
    logic [2:0] leds;
    gcd_pkg::gcd_pin_s sel_hi, sel_lo;
    logic signed [15:0] sense;
    int errors = 0, tests_run = 0, cyc = 0;
    // Register reads with their expected values
    logic [7:0] ra [9] = '{8'h00, 8'h28, 8'h20, 8'h24, 8'h2c, 8'h18, 8'h1c, 8'h30, 8'h3c};
    logic [31:0] ex [9] = '{32'h0000_0001, 32'h5678_1234, 32'h0bc0_1060, 32'h037f_1140,
        32'h0028_00bd, 32'h0000_0062, 32'h0000_00ff, 32'hffff_fc18, 32'h0000_0000};
    gcd_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
        .cell_select_hi(sel_hi), .cell_select_lo(sel_lo), .adc_start(adc_start),
        .adc_done(adc_done), .cell_sense_input(sense), .current_adc(16'h0064),
        .temp_raw_dt(16'h00fa), .discharging(dis), .smbc_high(smbc), .smbd_high(smbd),
        .mode_broadcast_en(1'b1), .filter_enable(filt), .host_pec_enable(hpec),
        .charger_pec_enable(cpec), .broadcast_enable(bc_en), .smart_charger_learning(smart),
        .led_segments(leds), .cfg_ready(rdy), .check_error(chk_err));
    gcd_partner i_mdl (.ref_clk(ref_clk), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_data(mem_data), .cell_select_hi(sel_hi),
        .cell_select_lo(sel_lo), .adc_start(adc_start), .adc_done(adc_done),
        .cell_sense_input(sense));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus access, held until waitrequest is seen low at a rising edge
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : acc
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    always #12.5 ref_clk = ~ref_clk;
    // Load, scan of eight steps and reads take about 3800 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        while (rdy !== 1'b1) @(posedge ref_clk);
        foreach (ra[i]) begin
            acc(1'b0, ra[i], 32'h0000_0000);
            chk(rd, ex[i]);
        end
        $display("test registers done");
        chk({29'h0, leds}, 32'h0000_0004);
        chk({28'h0, hpec, cpec, smart, bc_en}, 32'h0000_000e);
        dis <= 1'b1;
        smbc <= 1'b1;
        smbd <= 1'b1;
        @(negedge ref_clk);
        chk({31'h0, filt}, 32'h0000_0000);
        @(posedge ref_clk);
        smbd <= 1'b0;
        @(negedge ref_clk);
        chk({31'h0, filt}, 32'h0000_0001);
        $display("test controls done");
        @(posedge ref_clk);
        acc(1'b1, gcd_pkg::RA_CONTROL, 32'h0000_0002);
        while (i_mdl.conv_cnt < 8) @(posedge ref_clk);
        for (int k = 0; k < 4; k++) begin
            acc(1'b0, gcd_pkg::RA_CELL0 + 8'(4 * k), 32'h0000_0000);
            chk(rd, 32'(7 - 2 * k) * 32'h0000_0040);
        end
        $display("test scan done");
        acc(1'b1, gcd_pkg::RA_CONTROL, 32'h0000_0001);
        acc(1'b0, gcd_pkg::RA_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        while (rdy !== 1'b1) @(posedge ref_clk);
        acc(1'b0, gcd_pkg::RA_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        chk({31'h0, chk_err}, 32'h0000_0000);
        $display("test reload done");
        conclude();
    end
endmodule : tb
`default_nettype wire
